/* File: rtl/supervisor_i2c_target_port.sv */
// Serial two-wire target port with spike filters and register storage
`timescale 1ns/1ps
`include "i2c_target_params.svh"
// Behaviour
// RULE1: Target operation up to 1 MHz clock
// RULE2: Host alone drives clock; we never do
// RULE3: Host gives nine clock pulses per byte
// RULE4: Eight data bits, ninth acknowledge bit
// RULE5: Data line owner follows transfer direction
// RULE6: We answer on data during reads, writes
// RULE7: Reject spikes up to 50 ns
// RULE8: Drive low or release, never high
// RULE9: Host checks bus free, ends with STOP
// RULE10: Host clocks stuck data free, then STOP
// RULE11: Address, direction, register pointer, data bytes
module supervisor_i2c_target_port
  import i2c_target_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = `TARGET_ADDR_DEFAULT,
  parameter int FILT = `SPIKE_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Status
  output logic busy
);
  localparam int CW = $clog2(FILT + 1);

  // Synchronisers: stage one feeds stage two only
  logic [1:0] s1_r, s2_r;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= 2'h3;
      s2_r <= 2'h3;
    end else begin
      s1_r <= {scl_in, sda_in};
      s2_r <= s1_r;
    end
  end

  // Spike filters: a level is accepted only after it stands FILT cycles
  logic [1:0] filt_r, filt_nxt, filt_q;
  logic [CW-1:0] cnt_r [2];
  logic [CW-1:0] cnt_nxt [2];
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      always_comb begin
        cnt_nxt[g] = '0;
        filt_nxt[g] = filt_r[g];
        if (s2_r[g] != filt_r[g]) begin // RULE7
          if (cnt_r[g] == CW'(FILT - 1)) begin
            filt_nxt[g] = s2_r[g];
          end else begin
            cnt_nxt[g] = cnt_r[g] + CW'(1);
          end
        end
      end
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          cnt_r[g] <= '0;
          filt_r[g] <= 1'b1;
          filt_q[g] <= 1'b1;
        end else begin
          cnt_r[g] <= cnt_nxt[g];
          filt_r[g] <= filt_nxt[g];
          filt_q[g] <= filt_r[g];
        end
      end
    end
  endgenerate

  // Bus events from the filtered lines
  logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev;
  assign scl = filt_r[1];
  assign sda = filt_r[0];
  assign scl_rise = scl & ~filt_q[1];
  assign scl_fall = ~scl & filt_q[1];
  assign start_ev = scl & filt_q[1] & ~sda & filt_q[0];
  assign stop_ev = scl & filt_q[1] & sda & ~filt_q[0];

  // Protocol state
  tgt_state_t st_r, st_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic rw_r, rw_nxt, first_r, first_nxt, hit_r, hit_nxt;
  logic low_r, low_nxt, busy_r, busy_nxt;
  mem_req_t req;
  logic [7:0] rdata;

  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    first_nxt = first_r;
    hit_nxt = hit_r;
    low_nxt = low_r;
    busy_nxt = busy_r;
    req = '{we: 1'b0, addr: ptr_r, wdata: sh_r};
    if (start_ev) begin
      st_nxt = ST_ADDR;
      bit_nxt = 4'h0;
      low_nxt = 1'b0;
      busy_nxt = 1'b1;
    end else if (stop_ev) begin
      st_nxt = ST_IDLE;
      low_nxt = 1'b0;
      busy_nxt = 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE: begin
          low_nxt = 1'b0;
        end
        ST_ADDR, ST_WRITE: begin
          if (scl_rise) begin // RULE4
            sh_nxt = {sh_r[6:0], sda};
            bit_nxt = bit_r + 4'h1;
          end
          if (scl_fall && bit_r == `BITS_PER_BYTE) begin // RULE3
            bit_nxt = 4'h0;
            if (st_r == ST_ADDR) begin // RULE11
              hit_nxt = (sh_r[7:1] == TARGET_ADDR);
              rw_nxt = sh_r[0];
              first_nxt = ~sh_r[0];
              low_nxt = (sh_r[7:1] == TARGET_ADDR); // RULE6
              st_nxt = (sh_r[7:1] == TARGET_ADDR) ? ST_ACK : ST_IDLE;
            end else begin
              if (first_r) begin
                ptr_nxt = sh_r;
              end else begin
                req = '{we: 1'b1, addr: ptr_r, wdata: sh_r};
                ptr_nxt = ptr_r + 8'h01;
              end
              first_nxt = 1'b0;
              low_nxt = 1'b1; // RULE5
              st_nxt = ST_ACK;
            end
          end
        end
        ST_ACK: begin
          // Release or load first read bit as the acknowledge pulse ends
          if (scl_fall) begin
            if (rw_r) begin
              sh_nxt = rdata;
              ptr_nxt = ptr_r + 8'h01;
              low_nxt = ~rdata[7]; // RULE5
              bit_nxt = 4'h1;
              st_nxt = ST_READ;
            end else begin
              low_nxt = 1'b0;
              st_nxt = ST_WRITE;
            end
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            if (bit_r == `BITS_PER_BYTE) begin
              low_nxt = 1'b0; // RULE5
              st_nxt = ST_RACK;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              low_nxt = ~sh_r[6];
              bit_nxt = bit_r + 4'h1;
            end
          end
        end
        ST_RACK: begin
          // Host acknowledge keeps the read going, otherwise wait for STOP
          if (scl_rise) begin
            rw_nxt = ~sda;
            st_nxt = sda ? ST_IDLE : ST_ACK;
          end
        end
        default: begin
          st_nxt = ST_IDLE;
          low_nxt = 1'b0;
        end
      endcase
    end
  end

  // Read data is ready one cycle after the pointer sits still
  reg_mem #(.DEPTH(`REG_COUNT)) u_mem (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .req(req),
    .rdata(rdata)
  );

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= ST_IDLE;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      hit_r <= 1'b0;
      low_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      first_r <= first_nxt;
      hit_r <= hit_nxt;
      low_r <= low_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Open-drain data: only ever pulled low; the clock line is never driven
  assign sda_out = 1'b0; // RULE8 RULE2 RULE1
  assign sda_oe = low_r;
  assign busy = busy_r;

  // Checks
  chk_never_high: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE8
    sda_oe |-> !sda_out) else $error("data driven high");
  // A filtered level may only move once the synchronised line stood there FILT cycles
  chk_spike_reject: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE7
    $changed(filt_r[1]) |-> ($past(s2_r[1]) == filt_r[1])
      && ($past(s2_r[1], FILT) == filt_r[1]))
    else $error("short clock pulse passed");
  chk_sda_spike: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE7
    $changed(filt_r[0]) |-> ($past(s2_r[0]) == filt_r[0])
      && ($past(s2_r[0], FILT) == filt_r[0]))
    else $error("short data pulse passed");
  chk_ack_drive: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE6
    (st_r == ST_ADDR) && (st_nxt == ST_ACK) && !start_ev && !stop_ev |=> sda_oe)
    else $error("address not acknowledged");
  chk_write_ack: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE5
    (st_r == ST_WRITE) && (st_nxt == ST_ACK) && !start_ev && !stop_ev |=> sda_oe)
    else $error("write byte not acknowledged");
  chk_rack_release: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE5
    (st_r == ST_RACK) |-> !sda_oe) else $error("host acknowledge blocked");
  chk_nine_bits: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE3
    bit_r <= `BITS_PER_BYTE) else $error("byte count overrun");
  chk_stop_idle: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE11
    stop_ev && !start_ev |=> (st_r == ST_IDLE) && !sda_oe && !busy)
    else $error("stop not honoured");
  chk_idle_quiet: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE4
    (st_r == ST_IDLE) && $past(st_r == ST_IDLE) |-> !sda_oe)
    else $error("data driven while idle");
  // The data line is only pulled while our own address was matched
  chk_drive_addressed: assert property (@(posedge sys_clk) disable iff (sys_rst) // RULE11
    sda_oe |-> hit_r) else $error("data driven for another address");
endmodule : supervisor_i2c_target_port

/* File: rtl/i2c_target_params.svh */
// Constants for the supervisor serial target port
`ifndef I2C_TARGET_PARAMS_SVH
`define I2C_TARGET_PARAMS_SVH
`define CLK_PERIOD_NS 10
`define SPIKE_NS 50
`define SPIKE_CYCLES ((`SPIKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)
`define TARGET_ADDR_DEFAULT 7'h30
`define REG_COUNT 256
`define REG_RESET_VALUE 8'h00
`define BITS_PER_BYTE 4'h8
`endif

/* File: rtl/i2c_target_pkg.sv */
// Types for the supervisor serial target port
package i2c_target_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_WRITE = 3'b011,
    ST_READ = 3'b100,
    ST_RACK = 3'b101
  } tgt_state_t;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_t;
endpackage : i2c_target_pkg

/* File: rtl/reg_mem.sv */
// Byte register storage with registered read data
`timescale 1ns/1ps
`include "i2c_target_params.svh"
module reg_mem
  import i2c_target_pkg::*;
#(
  parameter int DEPTH = `REG_COUNT
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Access
  input wire mem_req_t req,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];
  logic [7:0] rdata_r;

  // Write port and registered read
  always_ff @(posedge sys_clk) begin
    if (req.we) begin
      mem[req.addr] <= req.wdata;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= `REG_RESET_VALUE;
    end else begin
      rdata_r <= mem[req.addr];
    end
  end

  assign rdata = rdata_r;
endmodule : reg_mem

/* File: testbench/i2c_host_model.sv */
// Host controller model for the two-wire bus
`timescale 1ns/1ps
module i2c_host_model #(
  parameter int Q = 25
) (
  // Clock and bus
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  // Both lines released at start
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Waits in falling edges of the system clock
  task automatic tk(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : tk
  // One bit slot of four quarters, 1 us long
  task automatic bit_slot(input logic b, input logic spk, output logic s);
    tk(Q);
    sda_low = ~b;
    if (spk) begin
      scl = 1'b1;
      tk(5);
      scl = 1'b0;
    end
    tk(Q);
    scl = 1'b1;
    tk(Q);
    s = sda_line;
    tk(Q);
    scl = 1'b0;
  endtask : bit_slot
  // START or repeated START once data is free
  task automatic start(output logic free);
    free = 1'b0;
    for (int i = 0; i < 400 && !free; i++) begin
      tk(1);
      free = sda_line;
    end
    sda_low = 1'b0;
    tk(Q);
    scl = 1'b1;
    tk(2 * Q);
    sda_low = 1'b1;
    tk(2 * Q);
    scl = 1'b0;
  endtask : start
  // STOP closes every transaction
  task automatic stop;
    sda_low = 1'b1;
    tk(Q);
    scl = 1'b1;
    tk(2 * Q);
    sda_low = 1'b0;
    tk(2 * Q);
  endtask : stop
  // Eight data slots then one acknowledge slot, MSB first
  task automatic xfer(input logic [7:0] d, input logic ackv, input logic spk,
                      output logic [7:0] seen, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], spk && i == 7, s);
      seen[i] = s;
    end
    bit_slot(ackv, 1'b0, ack);
  endtask : xfer
  // Clock until data goes high, then STOP
  task automatic recover(output logic freed);
    logic s;
    sda_low = 1'b0;
    for (int i = 0; i < 10 && !sda_line; i++) begin
      bit_slot(1'b1, 1'b0, s);
      tk(Q);
    end
    freed = sda_line;
    stop();
  endtask : recover
  // Short low pulse on data while idle
  task automatic spike_sda;
    sda_low = 1'b1;
    tk(5);
    sda_low = 1'b0;
  endtask : spike_sda
endmodule : i2c_host_model

/* File: testbench/supervisor_i2c_target_port_tb.sv */
// Bench for the supervisor serial target port
`timescale 1ns/1ps
module supervisor_i2c_target_port_tb;
  localparam logic [7:0] WA = 8'h60;
  localparam logic [7:0] RA = 8'h61;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic sda_out, sda_oe, busy, scl, host_low, sda_line;
  int err_count = 0;
  int checks = 0;
  // Clock
  always #5 sys_clk = ~sys_clk;
  // Wired data line with pull-up
  assign sda_line = ~(host_low | (sda_oe & ~sda_out));
  // Design and host
  supervisor_i2c_target_port dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy));
  i2c_host_model host (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_low(host_low));
  // Compare and count
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : cmp
  // Verdict
  task automatic end_of_test;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  // START after a bus-free check
  task automatic st;
    logic f;
    host.start(f);
    cmp({7'h00, f}, 8'h01);
    cmp({7'h00, busy}, 8'h01);
  endtask : st
  // One byte with its acknowledge
  task automatic bx(input logic [7:0] d, input logic a, input logic s, input logic [7:0] e,
                    input logic ea);
    logic [7:0] v;
    logic k;
    host.xfer(d, a, s, v, k);
    cmp(v, e);
    cmp({7'h00, k}, {7'h00, ea});
  endtask : bx
  // Write two bytes, read them back after a repeated START
  task automatic t_wr_rd;
    st();
    bx(WA, 1'b1, 1'b0, WA, 1'b0);
    bx(8'h10, 1'b1, 1'b0, 8'h10, 1'b0);
    bx(8'hA5, 1'b1, 1'b0, 8'hA5, 1'b0);
    bx(8'h3C, 1'b1, 1'b0, 8'h3C, 1'b0);
    st();
    bx(WA, 1'b1, 1'b0, WA, 1'b0);
    bx(8'h10, 1'b1, 1'b0, 8'h10, 1'b0);
    st();
    bx(RA, 1'b1, 1'b0, RA, 1'b0);
    bx(8'hFF, 1'b0, 1'b0, 8'hA5, 1'b0);
    bx(8'hFF, 1'b1, 1'b0, 8'h3C, 1'b1);
    host.stop();
  endtask : t_wr_rd
  // Other address is left unanswered
  task automatic t_other;
    st();
    bx(8'h62, 1'b1, 1'b0, 8'h62, 1'b1);
    bx(8'h55, 1'b1, 1'b0, 8'h55, 1'b1);
    host.stop();
  endtask : t_other
  // Spikes on both lines change nothing
  task automatic t_spike;
    logic seen_busy;
    seen_busy = 1'b0;
    host.spike_sda();
    repeat (100) begin
      @(negedge sys_clk);
      seen_busy = seen_busy | (busy !== 1'b0);
    end
    cmp({7'h00, seen_busy}, 8'h00);
    st();
    bx(WA, 1'b1, 1'b0, WA, 1'b0);
    bx(8'h20, 1'b1, 1'b1, 8'h20, 1'b0);
    bx(8'h5A, 1'b1, 1'b0, 8'h5A, 1'b0);
    bx(8'h00, 1'b1, 1'b0, 8'h00, 1'b0);
    st();
    bx(WA, 1'b1, 1'b0, WA, 1'b0);
    bx(8'h20, 1'b1, 1'b0, 8'h20, 1'b0);
    st();
    bx(RA, 1'b1, 1'b0, RA, 1'b0);
    bx(8'hFF, 1'b1, 1'b0, 8'h5A, 1'b1);
    host.stop();
  endtask : t_spike
  // Read cut short while the port holds data low
  task automatic t_stuck;
    logic s;
    logic f;
    st();
    bx(WA, 1'b1, 1'b0, WA, 1'b0);
    bx(8'h21, 1'b1, 1'b0, 8'h21, 1'b0);
    st();
    bx(RA, 1'b1, 1'b0, RA, 1'b0);
    repeat (3) host.bit_slot(1'b1, 1'b0, s);
    cmp({7'h00, sda_line}, 8'h00);
    host.recover(f);
    cmp({7'h00, f}, 8'h01);
    cmp({7'h00, busy}, 8'h00);
    t_other();
  endtask : t_stuck
  // Main sequence
  initial begin
    repeat (12) @(negedge sys_clk);
    cmp({6'h00, busy, sda_oe}, 8'h00);
    sys_rst = 1'b0;
    repeat (10) @(negedge sys_clk);
    t_wr_rd();
    t_other();
    t_spike();
    t_stuck();
    end_of_test();
  end
  // Hang limit
  initial begin
    #600us;
    err_count++;
    end_of_test();
  end
endmodule : supervisor_i2c_target_port_tb
